// *** logic/dlg_pkg.sv ***
package dlg_pkg;

  // Lane group shape
  localparam int DATA_LANES  = 42;
  localparam int SPARE_LANES = 2;
  localparam int PIN_LANES   = DATA_LANES + SPARE_LANES;
  localparam int MAX_RATIO   = 16;
  localparam int WORD_W      = DATA_LANES * MAX_RATIO;
  localparam int IDX_W       = 6;
  localparam int CNT_W       = 4;
  localparam int SPARE_LOW   = 42;
  localparam int SPARE_HIGH  = 43;

  // Repair halves and the two lanes that cannot be repaired
  localparam logic [IDX_W-1:0] LOW_HALF_LAST   = 6'h14;
  localparam logic [IDX_W-1:0] HIGH_HALF_FIRST = 6'h15;
  localparam logic [IDX_W-1:0] HIGH_HALF_LAST  = 6'h29;
  localparam logic [IDX_W-1:0] FIXED_LANE_LOW  = 6'h05;
  localparam logic [IDX_W-1:0] FIXED_LANE_HIGH = 6'h24;

  // Register offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_REPAIR = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // Control fields
  localparam int CTRL_ENABLE    = 0;
  localparam int CTRL_TRANSMIT  = 1;
  localparam int CTRL_RATIO_LSB = 2;
  localparam int CTRL_CLK_SWAP  = 4;
  localparam int CTRL_TX_INVERT = 5;
  localparam int CTRL_RX_INVERT = 6;
  localparam int CTRL_SWAP_LOW  = 7;
  localparam int CTRL_SWAP_HIGH = 8;
  localparam int CTRL_BITS      = 9;

  // Repair fields
  localparam int REP_LOW_EN   = 0;
  localparam int REP_LOW_IDX  = 1;
  localparam int REP_HIGH_EN  = 8;
  localparam int REP_HIGH_IDX = 9;

  // Status fields
  localparam int STAT_RUNNING  = 0;
  localparam int STAT_LOW_ACT  = 1;
  localparam int STAT_HIGH_ACT = 2;
  localparam int STAT_LOW_REJ  = 3;
  localparam int STAT_HIGH_REJ = 4;
  localparam int STAT_RX_CLK   = 5;

  // Values after reset
  localparam logic [CTRL_BITS-1:0] CTRL_RESET = 9'h000;
  localparam logic [1:0]           RATIO_RESET = 2'h0;

  typedef enum {DLG_IDLE, DLG_RUN} dlg_state_type;

  // Ratio code 0..3 selects 2, 4, 8 or 16 beats per core word
  function automatic logic [CNT_W-1:0] dlg_last_beat(input logic [1:0] code);
    dlg_last_beat = CNT_W'((2 << code) - 1);
  endfunction

  // Optional exchange of each spare lane with its unrepairable neighbour
  function automatic logic [PIN_LANES-1:0] dlg_swap_spares(input logic [PIN_LANES-1:0] v,
                                                          input logic lo,
                                                          input logic hi);
    logic [PIN_LANES-1:0] r;
    r = v;
    if (lo)
    begin
      r[SPARE_LOW]      = v[FIXED_LANE_LOW];
      r[FIXED_LANE_LOW] = v[SPARE_LOW];
    end
    if (hi)
    begin
      r[SPARE_HIGH]      = v[FIXED_LANE_HIGH];
      r[FIXED_LANE_HIGH] = v[SPARE_HIGH];
    end
    dlg_swap_spares = r;
  endfunction

endpackage

// *** logic/dlg_beat_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// One 42-bit beat each way between the gearbox and the lane mapper
interface dlg_beat_if;
  logic [41:0] tx_beat;
  logic [41:0] rx_beat;
  logic        rx_strobe;
  modport gear (output tx_beat, input rx_beat, input rx_strobe);
  modport map  (input tx_beat, output rx_beat, output rx_strobe);
endinterface
`default_nettype wire

// *** logic/dlg_gearbox.sv ***
`timescale 1ns/1ps
`default_nettype none
module dlg_gearbox
  import dlg_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic                 run,
  input  wire logic [1:0]           ratio_code,
  input  wire logic [WORD_W-1:0]    tx_word,
  output logic                      tx_take,
  output logic [WORD_W-1:0]         rx_word,
  output logic                      rx_word_valid,
  dlg_beat_if.gear                  beat
);
  import dlg_pkg::*;

  logic [CNT_W-1:0]  tx_cnt, next_tx_cnt;
  logic [WORD_W-1:0] tx_hold, next_tx_hold;
  logic [41:0]       tx_beat_q, next_tx_beat;
  logic [CNT_W-1:0]  rx_cnt, next_rx_cnt;
  logic [WORD_W-1:0] rx_buf, next_rx_buf;
  logic [WORD_W-1:0] next_rx_word;
  logic              next_rx_valid;
  logic [CNT_W-1:0]  last;

  assign last    = dlg_last_beat(ratio_code);
  assign tx_take = run && (tx_cnt == '0);
  assign beat.tx_beat = tx_beat_q;

  // Serializer: word taken at beat 0, sent low 42 bits first
  always_comb
  begin
    next_tx_cnt  = tx_cnt;
    next_tx_hold = tx_hold;
    next_tx_beat = tx_beat_q;
    if (!run)
    begin
      next_tx_cnt  = '0;
      next_tx_beat = '0;
    end
    else
    begin
      next_tx_cnt = (tx_cnt == last) ? '0 : tx_cnt + 1'b1;
      if (tx_cnt == '0)
      begin
        next_tx_hold = tx_word;
        next_tx_beat = tx_word[DATA_LANES-1:0];
      end
      else
        next_tx_beat = tx_hold[tx_cnt*DATA_LANES +: DATA_LANES];
    end
  end

  // Deserializer: beats fill the word from the low end up
  always_comb
  begin
    next_rx_cnt   = rx_cnt;
    next_rx_buf   = rx_buf;
    next_rx_word  = rx_word;
    next_rx_valid = 1'b0;
    if (!run)
      next_rx_cnt = '0;
    else if (beat.rx_strobe)
    begin
      next_rx_buf[rx_cnt*DATA_LANES +: DATA_LANES] = beat.rx_beat;
      if (rx_cnt == last)
      begin
        next_rx_cnt   = '0;
        next_rx_word  = next_rx_buf;
        next_rx_valid = 1'b1;
      end
      else
        next_rx_cnt = rx_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tx_cnt        <= '0;
      tx_hold       <= '0;
      tx_beat_q     <= '0;
      rx_cnt        <= '0;
      rx_buf        <= '0;
      rx_word       <= '0;
      rx_word_valid <= 1'b0;
    end
    else
    begin
      tx_cnt        <= next_tx_cnt;
      tx_hold       <= next_tx_hold;
      tx_beat_q     <= next_tx_beat;
      rx_cnt        <= next_rx_cnt;
      rx_buf        <= next_rx_buf;
      rx_word       <= next_rx_word;
      rx_word_valid <= next_rx_valid;
    end
  end
endmodule
`default_nettype wire

// *** logic/dlg_lane_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module dlg_lane_map
  import dlg_pkg::*;
(
  input  wire logic                 low_en,
  input  wire logic [IDX_W-1:0]     low_idx,
  input  wire logic                 high_en,
  input  wire logic [IDX_W-1:0]     high_idx,
  input  wire logic                 swap_low,
  input  wire logic                 swap_high,
  input  wire logic [PIN_LANES-1:0] pin_rx,
  input  wire logic                 pin_rx_strobe,
  output logic [PIN_LANES-1:0]      pin_tx,
  dlg_beat_if.map                   beat
);
  import dlg_pkg::*;

  logic [PIN_LANES-1:0] tx_map;
  logic [PIN_LANES-1:0] rx_unswap;
  logic [41:0]          rx_fix;

  // Transmit: copy the broken lane's bit onto its spare, spares idle otherwise
  always_comb
  begin
    tx_map = {2'b00, beat.tx_beat};
    if (low_en)
      tx_map[SPARE_LOW] = beat.tx_beat[low_idx];
    if (high_en)
      tx_map[SPARE_HIGH] = beat.tx_beat[high_idx];
    pin_tx = dlg_swap_spares(tx_map, swap_low, swap_high);
  end

  // Receive: restore the substituted bit, spares never leave this block
  always_comb
  begin
    rx_unswap = dlg_swap_spares(pin_rx, swap_low, swap_high);
    rx_fix    = rx_unswap[DATA_LANES-1:0];
    if (low_en)
      rx_fix[low_idx] = rx_unswap[SPARE_LOW];
    if (high_en)
      rx_fix[high_idx] = rx_unswap[SPARE_HIGH];
  end

  assign beat.rx_beat   = rx_fix;
  assign beat.rx_strobe = pin_rx_strobe;
endmodule
`default_nettype wire

// *** logic/dlg_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module dlg_top
  import dlg_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  // Register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  // Core side
  input  wire logic [WORD_W-1:0]    tx_word,
  output logic                      tx_take,
  output logic [WORD_W-1:0]         rx_word,
  output logic                      rx_word_valid,
  // Data and spare lanes, index 42 low spare, 43 high spare
  input  wire logic [PIN_LANES-1:0] lane_in,
  output logic [PIN_LANES-1:0]      lane_out,
  output logic [PIN_LANES-1:0]      lane_oe_n,
  // Clock pairs, each leg a two-way pin
  input  wire logic                 write_strobe_pair_t_in,
  input  wire logic                 write_strobe_pair_c_in,
  output logic                      write_strobe_pair_t_out,
  output logic                      write_strobe_pair_c_out,
  output logic                      write_strobe_pair_oe_n,
  input  wire logic                 read_strobe_pair_t_in,
  input  wire logic                 read_strobe_pair_c_in,
  output logic                      read_strobe_pair_t_out,
  output logic                      read_strobe_pair_c_out,
  output logic                      read_strobe_pair_oe_n
);
  import dlg_pkg::*;

  dlg_beat_if beat ();

  dlg_state_type        state, next_state;
  logic [CTRL_BITS-1:0] ctrl, next_ctrl;
  logic [1:0]           ratio, next_ratio;
  logic                 low_en, next_low_en;
  logic [IDX_W-1:0]     low_idx, next_low_idx;
  logic                 high_en, next_high_en;
  logic [IDX_W-1:0]     high_idx, next_high_idx;
  logic                 low_rej, next_low_rej;
  logic                 high_rej, next_high_rej;
  logic [31:0]          next_rdata;
  logic                 run, transmit, receive;
  logic [IDX_W-1:0]     wr_low_idx, wr_high_idx;
  logic                 wr_low_ok, wr_high_ok;
  logic [PIN_LANES-1:0] pin_tx;
  logic [PIN_LANES-1:0] lane_q, next_lane_q;
  logic                 fwd, next_fwd;
  logic                 drive, next_drive;
  logic [PIN_LANES-1:0] lane_s1, lane_s2;
  logic [1:0]           clk_s1, clk_s2;
  logic                 rclk_q, next_rclk_q;
  logic                 rclk_now;
  logic                 rx_strobe;
  logic                 clk_seen, next_clk_seen;

  // Only the true leg of each incoming pair is watched
  logic unused_c_legs;
  assign unused_c_legs = write_strobe_pair_c_in ^ read_strobe_pair_c_in;

  assign run      = (state == DLG_RUN);
  assign transmit = ctrl[CTRL_TRANSMIT];
  assign receive  = run && !transmit;

  // Repair targets checked per half; lanes 5 and 36 refused
  assign wr_low_idx  = reg_wdata[REP_LOW_IDX +: IDX_W];
  assign wr_high_idx = reg_wdata[REP_HIGH_IDX +: IDX_W];
  assign wr_low_ok   = (wr_low_idx <= LOW_HALF_LAST) && (wr_low_idx != FIXED_LANE_LOW);
  assign wr_high_ok  = (wr_high_idx >= HIGH_HALF_FIRST) && (wr_high_idx <= HIGH_HALF_LAST)
                       && (wr_high_idx != FIXED_LANE_HIGH);

  // Register writes; ratio and swaps only move while the group is stopped
  always_comb
  begin
    next_ctrl     = ctrl;
    next_ratio    = ratio;
    next_low_en   = low_en;
    next_low_idx  = low_idx;
    next_high_en  = high_en;
    next_high_idx = high_idx;
    next_low_rej  = low_rej;
    next_high_rej = high_rej;
    if (reg_wr && reg_addr == ADDR_CTRL)
    begin
      next_ctrl[CTRL_ENABLE]   = reg_wdata[CTRL_ENABLE];
      next_ctrl[CTRL_TRANSMIT] = reg_wdata[CTRL_TRANSMIT];
      if (!run)
      begin
        next_ctrl  = reg_wdata[CTRL_BITS-1:0];
        next_ratio = reg_wdata[CTRL_RATIO_LSB +: 2];
      end
    end
    if (reg_wr && reg_addr == ADDR_REPAIR)
    begin
      // A bad target leaves that half as it was and is flagged
      next_low_rej  = reg_wdata[REP_LOW_EN] && !wr_low_ok;
      next_high_rej = reg_wdata[REP_HIGH_EN] && !wr_high_ok;
      if (!reg_wdata[REP_LOW_EN] || wr_low_ok)
      begin
        next_low_en  = reg_wdata[REP_LOW_EN];
        next_low_idx = wr_low_idx;
      end
      if (!reg_wdata[REP_HIGH_EN] || wr_high_ok)
      begin
        next_high_en  = reg_wdata[REP_HIGH_EN];
        next_high_idx = wr_high_idx;
      end
    end
  end

  // Read data, valid the cycle after the read strobe only
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_CTRL:
        begin
          next_rdata[CTRL_BITS-1:0]       = ctrl;
          next_rdata[CTRL_RATIO_LSB +: 2] = ratio;
        end
        ADDR_REPAIR:
        begin
          next_rdata[REP_LOW_EN]            = low_en;
          next_rdata[REP_LOW_IDX +: IDX_W]  = low_idx;
          next_rdata[REP_HIGH_EN]           = high_en;
          next_rdata[REP_HIGH_IDX +: IDX_W] = high_idx;
        end
        ADDR_STATUS:
        begin
          next_rdata[STAT_RUNNING]  = run;
          next_rdata[STAT_LOW_ACT]  = low_en;
          next_rdata[STAT_HIGH_ACT] = high_en;
          next_rdata[STAT_LOW_REJ]  = low_rej;
          next_rdata[STAT_HIGH_REJ] = high_rej;
          next_rdata[STAT_RX_CLK]   = clk_seen;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Run state follows the enable bit
  always_comb
  begin
    case (state)
      DLG_IDLE: next_state = ctrl[CTRL_ENABLE] ? DLG_RUN : DLG_IDLE;
      DLG_RUN:  next_state = ctrl[CTRL_ENABLE] ? DLG_RUN : DLG_IDLE;
      default:  next_state = DLG_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state     <= DLG_IDLE;
      ctrl      <= CTRL_RESET;
      ratio     <= RATIO_RESET;
      low_en    <= 1'b0;
      low_idx   <= '0;
      high_en   <= 1'b0;
      high_idx  <= '0;
      low_rej   <= 1'b0;
      high_rej  <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      state     <= next_state;
      ctrl      <= next_ctrl;
      ratio     <= next_ratio;
      low_en    <= next_low_en;
      low_idx   <= next_low_idx;
      high_en   <= next_high_en;
      high_idx  <= next_high_idx;
      low_rej   <= next_low_rej;
      high_rej  <= next_high_rej;
      reg_rdata <= next_rdata;
    end
  end

  // Transmit pins: lanes and forwarded clock leave the same register stage
  // so every clock edge sits on a beat boundary
  always_comb
  begin
    next_drive  = run && transmit;
    next_lane_q = next_drive ? pin_tx : '0;
    next_fwd    = next_drive ? !fwd : 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      lane_q <= '0;
      fwd    <= 1'b0;
      drive  <= 1'b0;
    end
    else
    begin
      lane_q <= next_lane_q;
      fwd    <= next_fwd;
      drive  <= next_drive;
    end
  end

  assign lane_out  = lane_q;
  assign lane_oe_n = {PIN_LANES{!drive}};

  // Forwarded clock goes out on one pair; the other pair is left undriven
  always_comb
  begin
    write_strobe_pair_t_out = fwd ^ ctrl[CTRL_TX_INVERT];
    write_strobe_pair_c_out = !(fwd ^ ctrl[CTRL_TX_INVERT]);
    read_strobe_pair_t_out  = write_strobe_pair_t_out;
    read_strobe_pair_c_out  = write_strobe_pair_c_out;
    write_strobe_pair_oe_n  = !(drive && !ctrl[CTRL_CLK_SWAP]);
    read_strobe_pair_oe_n   = !(drive && ctrl[CTRL_CLK_SWAP]);
  end

  // Pin inputs pass two flip-flops before anything looks at them
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      lane_s1 <= '0;
      lane_s2 <= '0;
      clk_s1  <= 2'b00;
      clk_s2  <= 2'b00;
    end
    else
    begin
      lane_s1 <= lane_in;
      lane_s2 <= lane_s1;
      clk_s1  <= {write_strobe_pair_t_in, read_strobe_pair_t_in};
      clk_s2  <= clk_s1;
    end
  end

  // Each edge of the received clock, either direction, marks one beat;
  // the input of an unused pair is never looked at when transmitting
  always_comb
  begin
    rclk_now      = (ctrl[CTRL_CLK_SWAP] ? clk_s2[1] : clk_s2[0])
                    ^ ctrl[CTRL_RX_INVERT];
    next_rclk_q   = rclk_now;
    rx_strobe     = receive && (rclk_now != rclk_q);
    next_clk_seen = receive ? (clk_seen || rx_strobe) : 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rclk_q   <= 1'b0;
      clk_seen <= 1'b0;
    end
    else
    begin
      rclk_q   <= next_rclk_q;
      clk_seen <= next_clk_seen;
    end
  end

  dlg_gearbox u_gear (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .run           (run),
    .ratio_code    (ratio),
    .tx_word       (tx_word),
    .tx_take       (tx_take),
    .rx_word       (rx_word),
    .rx_word_valid (rx_word_valid),
    .beat          (beat.gear)
  );

  dlg_lane_map u_map (
    .low_en        (low_en),
    .low_idx       (low_idx),
    .high_en       (high_en),
    .high_idx      (high_idx),
    .swap_low      (ctrl[CTRL_SWAP_LOW]),
    .swap_high     (ctrl[CTRL_SWAP_HIGH]),
    .pin_rx        (lane_s2),
    .pin_rx_strobe (rx_strobe),
    .pin_tx        (pin_tx),
    .beat          (beat.map)
  );

endmodule
`default_nettype wire

// *** verification/dlg_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module dlg_top_asserts
  import dlg_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic                 reg_rd,
  input  wire logic [31:0]          reg_rdata,
  input  wire logic                 tx_take,
  input  wire logic                 rx_word_valid,
  input  wire logic [PIN_LANES-1:0] lane_out,
  input  wire logic [PIN_LANES-1:0] lane_oe_n,
  input  wire logic                 write_strobe_pair_t_out,
  input  wire logic                 write_strobe_pair_c_out,
  input  wire logic                 write_strobe_pair_oe_n,
  input  wire logic                 read_strobe_pair_oe_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Direction is one choice for every lane, spares included
  a_oe_group: assert property (lane_oe_n == '0 || lane_oe_n == '1)
    else $error("lane enables disagree");
  // A word spans at least two beats, so takes never abut
  a_take_gap: assert property (tx_take |=> !tx_take)
    else $error("core word taken twice in a row");
  // Once driving has settled the forwarded clock never pauses
  a_fwd_run: assert property (!write_strobe_pair_oe_n [*3]
    |-> write_strobe_pair_t_out != $past(write_strobe_pair_t_out))
    else $error("forwarded clock paused");
  // True and complement legs always opposite
  a_pair_diff: assert property (write_strobe_pair_t_out != write_strobe_pair_c_out)
    else $error("clock legs equal");
  // Released lanes and spares carry nothing
  a_spare_quiet: assert property ((&lane_oe_n) && $past(&lane_oe_n) |-> lane_out == '0)
    else $error("lane drive while released");
  // Read data only in the cycle after a read
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  // Received word valid is a single pulse
  a_valid_gap: assert property (rx_word_valid |=> !rx_word_valid)
    else $error("receive valid too long");
  // Never both clock pairs driven at once
  a_clk_oe_one: assert property (write_strobe_pair_oe_n || read_strobe_pair_oe_n)
    else $error("both clock pairs driven");
  // Words arrive only while the group listens
  a_rx_not_tx: assert property (rx_word_valid |-> &lane_oe_n)
    else $error("receive while transmitting");

  c_take: cover property (tx_take);
  c_rx_word: cover property (rx_word_valid);
  c_clk_swap: cover property (!read_strobe_pair_oe_n);
endmodule

bind dlg_top dlg_top_asserts dlg_top_asserts_inst (
  .mclk                    (mclk),
  .sys_rst                 (sys_rst),
  .reg_rd                  (reg_rd),
  .reg_rdata               (reg_rdata),
  .tx_take                 (tx_take),
  .rx_word_valid           (rx_word_valid),
  .lane_out                (lane_out),
  .lane_oe_n               (lane_oe_n),
  .write_strobe_pair_t_out (write_strobe_pair_t_out),
  .write_strobe_pair_c_out (write_strobe_pair_c_out),
  .write_strobe_pair_oe_n  (write_strobe_pair_oe_n),
  .read_strobe_pair_oe_n   (read_strobe_pair_oe_n)
);
`default_nettype wire

// *** verification/dlg_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module dlg_peer
  import dlg_pkg::*;
(
  input  wire logic                 mclk,
  output logic [PIN_LANES-1:0]      lane_in,
  output logic                      write_strobe_pair_t_in,
  output logic                      write_strobe_pair_c_in,
  output logic                      read_strobe_pair_t_in,
  output logic                      read_strobe_pair_c_in
);
  // Unused clock input held at a valid level, not floating
  assign write_strobe_pair_t_in = 1'b0;
  assign write_strobe_pair_c_in = 1'b1;

  // Clock stands still outside frames
  initial
  begin
    lane_in               = '0;
    read_strobe_pair_t_in = 1'b0;
    read_strobe_pair_c_in = 1'b1;
  end

  // One beat with a clock edge aligned to it, at most one edge per cycle
  task automatic send(input logic [PIN_LANES-1:0] b);
    @(posedge mclk);
    lane_in               <= b;
    read_strobe_pair_t_in <= ~read_strobe_pair_t_in;
    read_strobe_pair_c_in <= read_strobe_pair_t_in;
  endtask

  // Lanes no longer hold the last beat once the frame ends
  task automatic idle();
    @(posedge mclk);
    lane_in <= ~lane_in;
  endtask
endmodule
`default_nettype wire

// *** verification/dlg_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dlg_top_tb;
  import dlg_pkg::*;
  logic                 mclk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic [7:0]           reg_addr = 8'h00;
  logic [31:0]          reg_wdata = 32'h0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [31:0]          reg_rdata;
  logic [WORD_W-1:0]    tx_word = {21{32'hc3a5_9617}};
  logic                 tx_take;
  logic [WORD_W-1:0]    rx_word;
  logic                 rx_word_valid;
  logic [PIN_LANES-1:0] lane_in;
  logic [PIN_LANES-1:0] lane_out;
  logic [PIN_LANES-1:0] lane_oe_n;
  logic                 ws_t_in, ws_c_in, rs_t_in, rs_c_in;
  logic                 ws_t_out, ws_c_out, ws_oe_n, rs_t_out, rs_c_out, rs_oe_n;
  int                   fail_count = 0;
  int                   compares = 0;
  int                   cycles = 0;

  always #2 mclk = ~mclk;

  dlg_top dlg_top_inst (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_word(tx_word), .tx_take(tx_take), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
    .lane_in(lane_in), .lane_out(lane_out), .lane_oe_n(lane_oe_n),
    .write_strobe_pair_t_in(ws_t_in), .write_strobe_pair_c_in(ws_c_in),
    .write_strobe_pair_t_out(ws_t_out), .write_strobe_pair_c_out(ws_c_out),
    .write_strobe_pair_oe_n(ws_oe_n), .read_strobe_pair_t_in(rs_t_in),
    .read_strobe_pair_c_in(rs_c_in), .read_strobe_pair_t_out(rs_t_out),
    .read_strobe_pair_c_out(rs_c_out), .read_strobe_pair_oe_n(rs_oe_n));

  dlg_peer dlg_peer_inst (.mclk(mclk), .lane_in(lane_in),
    .write_strobe_pair_t_in(ws_t_in), .write_strobe_pair_c_in(ws_c_in),
    .read_strobe_pair_t_in(rs_t_in), .read_strobe_pair_c_in(rs_c_in));

  task automatic stop_test();
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(96'(reg_rdata), 96'(e));
  endtask

  // Bounded wait for a one-cycle flag, sampled mid-cycle
  task automatic wait_flag(ref logic f);
    int n;
    n = 0;
    @(negedge mclk);
    while (f !== 1'b1 && n < 60)
    begin
      @(negedge mclk);
      n++;
    end
  endtask

  // Pins for one beat with lanes 20 and 21 broken and carried by the spares
  function automatic logic [PIN_LANES-1:0] brk(input logic [41:0] b);
    logic [PIN_LANES-1:0] p;
    p = {b[21], b[20], b};
    p[20] = ~b[20];
    p[21] = ~b[21];
    return p;
  endfunction

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      fail_count++;
      stop_test();
    end
  end

  initial
  begin
    logic [31:0]          ctl;
    logic [41:0]          bt, ba, bb;
    logic [PIN_LANES-1:0] p;
    logic                 t;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    // Unmapped write is ignored, everything reads zero after reset
    wr(8'h0c, 32'hffff_ffff);
    for (int i = 0; i < 4; i++)
      rd_chk(8'(4 * i), 32'h0);
    chk(96'(lane_oe_n), 96'(44'hfff_ffff_ffff));
    // Valid repair, then bad lanes 5/36, then 21/20 out of their halves
    wr(ADDR_REPAIR, 32'h5107);
    rd_chk(ADDR_REPAIR, 32'h5107);
    rd_chk(ADDR_STATUS, 32'h06);
    wr(ADDR_REPAIR, 32'h490b);
    rd_chk(ADDR_REPAIR, 32'h5107);
    rd_chk(ADDR_STATUS, 32'h1e);
    wr(ADDR_REPAIR, 32'h292b);
    rd_chk(ADDR_STATUS, 32'h1e);
    wr(ADDR_REPAIR, 32'h2b29);
    rd_chk(ADDR_STATUS, 32'h06);
    // Every ratio; spare swaps, clock swap and inversion ride along
    for (int c = 0; c < 4; c++)
    begin
      ctl = 32'h3 | (32'(c) << 2) | (32'(c) << 7);
      ctl = ctl | ((c == 2) ? 32'h10 : (c == 3) ? 32'h20 : 32'h0);
      wr(ADDR_CTRL, ctl);
      wait_flag(tx_take);
      chk(96'(tx_take), 96'(1'b1));
      repeat (2) @(posedge mclk);
      for (int k = 0; k < (2 << c); k++)
      begin
        @(negedge mclk);
        bt = tx_word[42 * k +: 42];
        p = {bt[21], bt[20], bt};
        if (c[0])
        begin
          t = p[5];
          p[5] = p[42];
          p[42] = t;
        end
        if (c[1])
        begin
          t = p[36];
          p[36] = p[43];
          p[43] = t;
        end
        chk(96'(lane_out), 96'(p));
        // Forwarded clock starts high (low when inverted) one edge before beat 0, then flips with each beat
        t = k[0] ^ (c == 3);
        chk(96'({ws_t_out, ws_c_out, rs_t_out, rs_c_out}), 96'({2{t, !t}}));
      end
      chk(96'(lane_oe_n), 96'(0));
      chk(96'({ws_oe_n, rs_oe_n}), 96'((c == 2) ? 2'b10 : 2'b01));
      wr(ADDR_CTRL, 32'h0);
      repeat (4) @(posedge mclk);
    end
    // Receive two beats with both halves repaired
    wr(ADDR_CTRL, 32'h1);
    repeat (4) @(posedge mclk);
    ba = 42'h2a50f0f3c3c;
    bb = 42'h15af0f0c3c3;
    dlg_peer_inst.send(brk(ba));
    dlg_peer_inst.send(brk(bb));
    dlg_peer_inst.idle();
    wait_flag(rx_word_valid);
    chk(96'(rx_word_valid), 96'(1'b1));
    chk(96'(rx_word[83:0]), 96'({bb, ba}));
    chk(96'({lane_oe_n, ws_oe_n, rs_oe_n}), 96'(46'h3fff_ffff_ffff));
    rd_chk(ADDR_STATUS, 32'h27);
    // Direction turned round at run time
    wr(ADDR_CTRL, 32'h3);
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk(96'(lane_oe_n), 96'(0));
    wr(ADDR_CTRL, 32'h0);
    repeat (4) @(posedge mclk);
    stop_test();
  end
endmodule
`default_nettype wire
